// ### design/pmic_mode_params.svh
// Constants of the power mode sequencer
`ifndef PMIC_MODE_PARAMS_SVH
`define PMIC_MODE_PARAMS_SVH
`define SYS_CLK_HZ 50000000
`define SLOW_TICK_HZ 32768
`define SHIP_HOLD_MS 2000
`define RESET_PRESS_MS 10000
`define POWER_DOWN_DELAY_MS 100
`define THERMAL_WARN_DEFAULT 8'h55
`define THERMAL_WARN_HYS 8'h0a
`endif

// ### design/pmic_mode_pkg.sv
// Types of the power mode sequencer
package pmic_mode_pkg;
  typedef enum logic [3:0] {
    ST_NO_SUPPLY,
    ST_COLD_START,
    ST_ACTIVE,
    ST_SHIP,
    ST_HIBERNATE,
    ST_HIBERNATE_PASSTHROUGH,
    ST_POWER_CYCLE,
    ST_WATCHDOG_RESET,
    ST_WAKE_UP
  } pmic_state_t;

  typedef struct packed {
    logic ship;
    logic hibernate;
    logic hibernate_passthrough;
  } mode_request_t;

  typedef struct packed {
    logic boost_enable;
    logic boost_ulp;
    logic boost_passthrough;
    logic linear_regulator_switch;
    logic regulated_output_discharge;
    logic linear_regulator_output_discharge;
    logic wake_timer_run;
  } regulator_ctrl_t;
endpackage

// ### design/hold_counter.sv
// Counts slow ticks while a condition holds and flags the hold time
`timescale 1ns/1ps
module hold_counter #(
  parameter int unsigned COUNT = 10
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic hold,
  output logic done
);
  localparam int unsigned W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn || !hold)
      cnt_reg <= '0;
    else if (tick && cnt_reg != LAST)
      cnt_reg <= cnt_reg + W'(1);
  end

  assign done = hold && (cnt_reg == LAST);
endmodule // hold_counter

// ### design/pmic_mode_state_machine.sv
// Supervisory supply and mode state machine of the power management chip
// Summary of operation
// - Each domain leaves reset on its rising comparator
// - Internal brownout sends machine to cold start, except from pass-through hibernate
// - Battery falling below threshold gives no supply
// - Thermal shutdown in active goes cold start
// - Return to active once temperature clears
// - Temperature evaluated only in high power
// - Warning level raises host interrupt, with hysteresis
// - Active drives power good high unless pressed
// - Host mode requests act from active mode
// - Ship button held two seconds enters ship
// - Reset button long press enters power cycle
// - Watchdog expiry enters watchdog reset state
// - Boost overcurrent in active enters power cycle
// - Hibernate: discharge, ultra-low power, power good low
// - Hibernate wake pin or timer goes wake up
// - Pass-through hibernate: discharge, regulator off, low
// - Pass-through wake goes cold start, resets registers
// - Ship disables all but output discharge, only wake pin wakes
// - Power cycle disables regulators, discharges, resets registers
// - After power down delay, return to active
`timescale 1ns/1ps
`include "pmic_mode_params.svh"
module pmic_mode_state_machine
  import pmic_mode_pkg::*;
#(
  parameter int unsigned SHIP_HOLD_TICKS = `SHIP_HOLD_MS * `SLOW_TICK_HZ / 1000,
  parameter int unsigned RESET_PRESS_TICKS = `RESET_PRESS_MS * `SLOW_TICK_HZ / 1000,
  parameter int unsigned POWER_DOWN_TICKS = `POWER_DOWN_DELAY_MS * `SLOW_TICK_HZ / 1000
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic slow_tick,
  input wire logic battery_above_por_rising,
  input wire logic battery_above_por_falling,
  input wire logic internal_supply_above_por,
  input wire logic internal_supply_above_bor,
  input wire logic boost_high_power,
  input wire logic thermal_shutdown_level,
  input wire logic [7:0] die_temperature,
  input wire logic [7:0] thermal_warning_level,
  input wire logic ship_button,
  input wire logic reset_button,
  input wire logic ship_hold_wake_pin,
  input wire logic wake_timer_event,
  input wire logic wake_timer_enable,
  input wire logic linear_regulator_hibernate_on,
  input wire logic watchdog_expired,
  input wire logic boost_overcurrent,
  input wire mode_request_t mode_request,
  output pmic_state_t state,
  output regulator_ctrl_t regulator_ctrl,
  output logic power_good_reset_out,
  output logic battery_domain_reset,
  output logic internal_domain_reset,
  output logic register_reset,
  output logic thermal_warning_irq
);
  pmic_state_t state_reg;
  pmic_state_t state_next;
  regulator_ctrl_t ctrl_next;
  logic battery_up_reg;
  logic internal_up_reg;
  logic warn_reg;
  logic ship_held;
  logic reset_held;
  logic pwrdn_done;
  logic hot;
  logic [8:0] warn_low;

  hold_counter #(.COUNT(SHIP_HOLD_TICKS)) u_ship_hold (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .tick(slow_tick),
    .hold(ship_button && state_reg == ST_ACTIVE),
    .done(ship_held)
  );

  hold_counter #(.COUNT(RESET_PRESS_TICKS)) u_reset_press (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .tick(slow_tick),
    .hold(reset_button && state_reg == ST_ACTIVE),
    .done(reset_held)
  );

  hold_counter #(.COUNT(POWER_DOWN_TICKS)) u_power_down (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .tick(slow_tick),
    .hold(state_reg == ST_POWER_CYCLE),
    .done(pwrdn_done)
  );

  assign hot = thermal_shutdown_level && boost_high_power;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      battery_up_reg <= 1'b0;
      internal_up_reg <= 1'b0;
    end
    else
    begin
      if (!battery_above_por_falling)
        battery_up_reg <= 1'b0;
      else if (battery_above_por_rising)
        battery_up_reg <= 1'b1;
      if (!internal_supply_above_bor || !battery_up_reg)
        internal_up_reg <= 1'b0;
      else if (internal_supply_above_por)
        internal_up_reg <= 1'b1;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_NO_SUPPLY:
        if (battery_up_reg)
          state_next = ST_COLD_START;
      ST_COLD_START:
        if (internal_up_reg && !hot)
          state_next = ST_ACTIVE;
      ST_ACTIVE:
        // Thermal then overcurrent outrank the other active exits; reset press outranks watchdog, which outranks ship button and host requests
        if (hot)
          state_next = ST_COLD_START;
        else if (boost_overcurrent)
          state_next = ST_POWER_CYCLE;
        else if (reset_held)
          state_next = ST_POWER_CYCLE;
        else if (watchdog_expired)
          state_next = ST_WATCHDOG_RESET;
        else if (ship_held)
          state_next = ST_SHIP;
        else if (mode_request.ship)
          state_next = ST_SHIP;
        else if (mode_request.hibernate_passthrough)
          state_next = ST_HIBERNATE_PASSTHROUGH;
        else if (mode_request.hibernate)
          state_next = ST_HIBERNATE;
      ST_SHIP:
        if (ship_hold_wake_pin)
          state_next = ST_WAKE_UP;
      ST_HIBERNATE:
        if (ship_hold_wake_pin || (wake_timer_enable && wake_timer_event))
          state_next = ST_WAKE_UP;
      ST_HIBERNATE_PASSTHROUGH:
        if (ship_hold_wake_pin || (wake_timer_enable && wake_timer_event))
          state_next = ST_COLD_START;
      ST_POWER_CYCLE:
        if (pwrdn_done)
          state_next = ST_ACTIVE;
      // Watchdog reset passes through a power cycle to active; wake up goes straight to active
      ST_WATCHDOG_RESET:
        state_next = ST_POWER_CYCLE;
      ST_WAKE_UP:
        state_next = ST_ACTIVE;
      default:
        state_next = ST_COLD_START;
    endcase
    if (!internal_up_reg && state_next != ST_NO_SUPPLY && state_reg != ST_NO_SUPPLY
        && state_reg != ST_HIBERNATE_PASSTHROUGH)
      state_next = ST_COLD_START;
    if (!battery_up_reg)
      state_next = ST_NO_SUPPLY;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      state_reg <= ST_NO_SUPPLY;
    else
      state_reg <= state_next;
  end

  always_comb
  begin
    ctrl_next = '0;
    unique case (state_next)
      ST_ACTIVE, ST_WAKE_UP:
      begin
        ctrl_next.boost_enable = 1'b1;
        ctrl_next.linear_regulator_switch = 1'b1;
      end
      ST_COLD_START:
        ctrl_next.boost_enable = 1'b1;
      ST_HIBERNATE:
      begin
        ctrl_next.boost_enable = 1'b1;
        ctrl_next.boost_ulp = 1'b1;
        ctrl_next.linear_regulator_switch = linear_regulator_hibernate_on;
        ctrl_next.regulated_output_discharge = 1'b1;
        ctrl_next.wake_timer_run = wake_timer_enable;
      end
      ST_HIBERNATE_PASSTHROUGH:
      begin
        ctrl_next.boost_enable = 1'b1;
        ctrl_next.boost_passthrough = 1'b1;
        ctrl_next.regulated_output_discharge = 1'b1;
        ctrl_next.wake_timer_run = wake_timer_enable;
      end
      ST_POWER_CYCLE, ST_WATCHDOG_RESET:
      begin
        ctrl_next.regulated_output_discharge = 1'b1;
        ctrl_next.linear_regulator_output_discharge = 1'b1;
      end
      ST_SHIP:
        ctrl_next.regulated_output_discharge = 1'b1;
      ST_NO_SUPPLY:
        ctrl_next = '0;
      default:
        ctrl_next = '0;
    endcase
  end

  // Outputs registered from next state, domain resets from the supply flags, so they align with state
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state <= ST_NO_SUPPLY;
      regulator_ctrl <= '0;
      power_good_reset_out <= 1'b0;
      battery_domain_reset <= 1'b1;
      internal_domain_reset <= 1'b1;
      register_reset <= 1'b1;
    end
    else
    begin
      state <= state_next;
      regulator_ctrl <= ctrl_next;
      power_good_reset_out <= (state_next == ST_ACTIVE) && !reset_button;
      battery_domain_reset <= !battery_up_reg;
      internal_domain_reset <= !internal_up_reg;
      register_reset <= state_next == ST_POWER_CYCLE || state_next == ST_WATCHDOG_RESET
        || state_next == ST_COLD_START || state_next == ST_NO_SUPPLY;
    end
  end

  // Hysteresis floor below zero clears the warning at any temperature under the level
  assign warn_low = {1'b0, thermal_warning_level} - {1'b0, 8'(`THERMAL_WARN_HYS)};

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      warn_reg <= 1'b0;
    else if (!boost_high_power || state_reg != ST_ACTIVE)
      warn_reg <= 1'b0;
    else if (die_temperature >= thermal_warning_level)
      warn_reg <= 1'b1;
    else if (warn_low[8] || die_temperature < warn_low[7:0])
      warn_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      thermal_warning_irq <= 1'b0;
    else
      thermal_warning_irq <= warn_reg;
  end
endmodule // pmic_mode_state_machine

// ### tb/pmic_mode_properties.sv
// Port checker of the power mode sequencer
`timescale 1ns/1ps
module pmic_mode_properties
  import pmic_mode_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic battery_above_por_falling,
  input wire logic internal_supply_above_bor,
  input wire logic boost_high_power,
  input wire logic thermal_shutdown_level,
  input wire pmic_state_t state,
  input wire regulator_ctrl_t regulator_ctrl,
  input wire logic power_good_reset_out,
  input wire logic register_reset
);
  regulator_ctrl_t c;
  assign c = regulator_ctrl;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  AST_PG: assert property (power_good_reset_out |-> state == ST_ACTIVE) // level
    else $error("pg high outside active");
  AST_BAT: assert property (!battery_above_por_falling // drop
    |-> ##[1:2] state == ST_NO_SUPPLY) else $error("battery drop missed");
  AST_BOR: assert property (state == ST_ACTIVE && !internal_supply_above_bor // sag
    |-> ##[1:2] state == ST_COLD_START) else $error("brownout missed");
  AST_TSD: assert property (state == ST_ACTIVE && boost_high_power // heat
    && thermal_shutdown_level |-> ##[1:2] state == ST_COLD_START) else $error("hot missed");
  AST_WDOG: assert property (state == ST_WATCHDOG_RESET |=> state == ST_POWER_CYCLE) // exit
    else $error("watchdog stuck");
  AST_WAKE: assert property (state == ST_WAKE_UP |=> state == ST_ACTIVE) // exit
    else $error("wake up stuck");
  AST_CYCLE: assert property (state == ST_POWER_CYCLE |-> !c.boost_enable // off
    && !c.linear_regulator_switch && c.regulated_output_discharge
    && c.linear_regulator_output_discharge && register_reset) else $error("cycle outputs");
  AST_HIB_PT: assert property (state == ST_HIBERNATE_PASSTHROUGH |-> c.boost_passthrough // pt
    && !c.linear_regulator_switch && c.regulated_output_discharge) else $error("pt outputs");
  AST_HIB: assert property (state == ST_HIBERNATE |-> c.boost_ulp // hib
    && c.regulated_output_discharge && !power_good_reset_out) else $error("hib outputs");
  C_SHIP: cover property (state == ST_SHIP);
  C_HIB: cover property (state == ST_HIBERNATE);
  C_CYCLE: cover property (state == ST_POWER_CYCLE);
endmodule // pmic_mode_properties
bind pmic_mode_state_machine pmic_mode_properties i_pmic_mode_properties (.*);

// ### tb/pmic_host_model.sv
// Host and push-button model
`timescale 1ns/1ps
module pmic_host_model
  import pmic_mode_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [2:0] cmd,
  input wire logic [1:0] btn,
  output mode_request_t mode_request = '0,
  output logic ship_button = 1'b0,
  output logic reset_button = 1'b0
);
  // request and hold
  // Changes only off the falling edge so the sequencer never sees a half-set request
  always @(negedge sys_clk)
  begin
    mode_request <= cmd;
    {ship_button, reset_button} <= btn;
  end
endmodule // pmic_host_model

// ### tb/pmic_mode_state_machine_tb_top.sv
// Self-checking bench of the power mode sequencer
`timescale 1ns/1ps
module pmic_mode_state_machine_tb_top
  import pmic_mode_pkg::*;
;
  logic sys_clk, rstn, slow_tick, battery_above_por_rising, battery_above_por_falling;
  logic internal_supply_above_por, internal_supply_above_bor, boost_high_power;
  logic thermal_shutdown_level, ship_hold_wake_pin, wake_timer_event, wake_timer_enable;
  logic linear_regulator_hibernate_on, watchdog_expired, boost_overcurrent, ship_button;
  logic reset_button, power_good_reset_out, battery_domain_reset, internal_domain_reset;
  logic register_reset, thermal_warning_irq, p;
  logic [7:0] die_temperature, thermal_warning_level;
  logic [2:0] cmd;
  logic [1:0] btn;
  mode_request_t mode_request;
  pmic_state_t state;
  regulator_ctrl_t regulator_ctrl;
  int mismatches, num_checks, cyc, seed, i;
  pmic_host_model i_pmic_host_model (.*);
  pmic_mode_state_machine #(.SHIP_HOLD_TICKS(3), .RESET_PRESS_TICKS(4), .POWER_DOWN_TICKS(3))
    i_pmic_mode_state_machine (.*);
  initial
  begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Slow tick every fourth cycle; the run is cut short well past its expected length
  always @(negedge sys_clk)
  begin
    cyc <= cyc + 1;
    slow_tick <= cyc % 4 == 0;
    if (cyc == 3000)
      end_of_test(1);
  end
  task automatic chk(input string n, input logic [7:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wst(input pmic_state_t s, input int n);
    repeat (n)
      if (state !== s)
        @(negedge sys_clk);
    chk("state", s, state);
  endtask
  task automatic up();
    {battery_above_por_rising, battery_above_por_falling} = 2'b11;
    wst(ST_ACTIVE, 9); // power-up
    chk("pg", 1, power_good_reset_out); // active
    chk("domains", 0, {battery_domain_reset, internal_domain_reset}); // released
  endtask
  task automatic drop();
    {battery_above_por_rising, battery_above_por_falling} = 0;
    wst(ST_NO_SUPPLY, 4); // drop
    chk("bat rst", 1, battery_domain_reset); // reset
    up();
  endtask
  function automatic logic irq_exp(input logic [7:0] t, l, input logic q);
    return t > l ? 1'b1 : t < l - 8'h0a ? 1'b0 : q;
  endfunction
  task automatic end_of_test(input int extra);
    mismatches += extra;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    seed = 32'h56a95f3d;
    {rstn, boost_high_power, thermal_shutdown_level, ship_hold_wake_pin, p} = 0;
    {wake_timer_event, wake_timer_enable, watchdog_expired, boost_overcurrent, cmd, btn} = 0;
    {battery_above_por_rising, battery_above_por_falling} = 0;
    {internal_supply_above_por, internal_supply_above_bor} = 2'b11;
    linear_regulator_hibernate_on = 1'($random(seed));
    {die_temperature, thermal_warning_level} = 16'h0055;
    cy(16);
    rstn = 1;
    up();
    cmd = 3'b010;
    wst(ST_HIBERNATE, 6); // request
    chk("ldo", linear_regulator_hibernate_on, regulator_ctrl.linear_regulator_switch); // ldo
    {cmd, wake_timer_event} = 4'h1;
    cy(4);
    chk("gated", ST_HIBERNATE, state); // timer disabled
    wake_timer_enable = 1;
    wst(ST_WAKE_UP, 3); // timer
    {cmd, wake_timer_event} = 4'h2;
    wst(ST_HIBERNATE_PASSTHROUGH, 8); // request
    {cmd, ship_hold_wake_pin} = 4'h1;
    wst(ST_COLD_START, 3); // wake
    chk("regs", 1, register_reset); // reset
    ship_hold_wake_pin = 0;
    wst(ST_ACTIVE, 9); // restart
    {cmd, wake_timer_event} = 4'h9;
    wst(ST_SHIP, 6); // request
    cmd = 0;
    cy(4);
    chk("ship", ST_SHIP, state); // timer ignored
    wake_timer_event = 0;
    drop();
    // Six cycles hold at most two ticks, short of the three-tick hold time
    btn = 2'b10;
    cy(6);
    btn = 0;
    cy(2);
    btn = 2'b10;
    cy(6);
    chk("hold", ST_ACTIVE, state); // restart
    wst(ST_SHIP, 20); // hold
    btn = 0;
    drop();
    btn = 1;
    cy(2);
    chk("pg low", 0, power_good_reset_out); // pressed
    wst(ST_POWER_CYCLE, 30); // press
    btn = 0;
    wst(ST_ACTIVE, 30); // delay
    for (i = 1; i < 3; i++)
    begin
      {watchdog_expired, boost_overcurrent} = 2'(i);
      wst(i == 1 ? ST_POWER_CYCLE : ST_WATCHDOG_RESET, 3); // events
      {watchdog_expired, boost_overcurrent} = 0;
      wst(ST_ACTIVE, 30); // delay
    end
    thermal_shutdown_level = 1;
    cy(5);
    chk("no hp", ST_ACTIVE, state); // ignored
    boost_high_power = 1;
    wst(ST_COLD_START, 3); // hot
    thermal_shutdown_level = 0;
    wst(ST_ACTIVE, 9); // cooled
    for (i = 0; i < 9; i++)
    begin
      if (i % 3 == 0)
        thermal_warning_level = 8'h55 + 8'($unsigned($random(seed)) % 21);
      die_temperature = thermal_warning_level + (i % 3 == 0 ? 8'h01 : i % 3 == 1 ? 8'hfb : 8'hf5);
      p = irq_exp(die_temperature, thermal_warning_level, p);
      cy(3);
      chk("irq", p, thermal_warning_irq); // warning
    end
    internal_supply_above_bor = 0;
    wst(ST_COLD_START, 3); // brownout
    chk("int rst", 1, internal_domain_reset); // reset
    internal_supply_above_bor = 1;
    drop();
    end_of_test(0);
  end
endmodule // pmic_mode_state_machine_tb_top
